// ### common/supervisor_pkg.sv
// constants for the watchdog and power button supervisor
package supervisor_pkg;

  // clock and time bases
  localparam longint CLK_PERIOD_NS    = 20;
  localparam longint WD_BASE_NS       = 256_000_000;
  localparam longint BTN_BASE_NS      = 1_000_000_000;
  localparam longint WD_BASE_CYCLES   = (WD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint BTN_BASE_CYCLES  = (BTN_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int     CNT_W            = 33;

  // register indices; byte address is four times the index
  localparam logic [15:0] REG_WD_IDX    = 16'h4004;
  localparam logic [15:0] REG_BTN_IDX   = 16'h4005;
  localparam logic [15:0] REG_KEY_IDX   = 16'h4008;
  localparam logic [15:0] REG_IRQ_IDX   = 16'h4010;
  localparam logic [15:0] REG_MASK_IDX  = 16'h4011;
  localparam logic [31:0] ADDR_WD       = {14'h0000, REG_WD_IDX, 2'b00};
  localparam logic [31:0] ADDR_BTN      = {14'h0000, REG_BTN_IDX, 2'b00};
  localparam logic [31:0] ADDR_KEY      = {14'h0000, REG_KEY_IDX, 2'b00};
  localparam logic [31:0] ADDR_IRQ      = {14'h0000, REG_IRQ_IDX, 2'b00};
  localparam logic [31:0] ADDR_MASK     = {14'h0000, REG_MASK_IDX, 2'b00};
  localparam logic [15:0] KEY_VALUE     = 16'h9716;

  // watchdog field positions
  localparam int WD_ENA_BIT     = 15;
  localparam int WD_PAUSE_BIT   = 14;
  localparam int WD_SRC_BIT     = 13;
  localparam int WD_SLP_BIT     = 12;
  localparam int WD_REFRESH_BIT = 11;
  localparam int WD_SEC_LSB     = 8;
  localparam int WD_PRI_LSB     = 4;
  localparam int WD_TO_LSB      = 0;

  // button field positions
  localparam int BTN_HOLD_LSB   = 8;
  localparam int BTN_PRESS_LSB  = 4;
  localparam int BTN_LEVEL_BIT  = 3;
  localparam int BTN_TO_LSB     = 0;

  // values after reset
  localparam logic       WD_ENA_RST     = 1'b1;
  localparam logic       WD_PAUSE_RST   = 1'b0;
  localparam logic       WD_SRC_RST     = 1'b1;
  localparam logic       WD_SLP_RST     = 1'b0;
  localparam logic [1:0] WD_SEC_RST     = 2'h2;
  localparam logic [1:0] WD_PRI_RST     = 2'h1;
  localparam logic [2:0] WD_TO_RST      = 3'h7;
  localparam logic [1:0] BTN_HOLD_RST   = 2'h1;
  localparam logic [1:0] BTN_PRESS_RST  = 2'h0;
  localparam logic [1:0] BTN_TO_RST     = 2'h0;

  // action encodings
  localparam logic [1:0] WD_ACT_NONE    = 2'h0;
  localparam logic [1:0] WD_ACT_IRQ     = 2'h1;
  localparam logic [1:0] WD_ACT_RESET   = 2'h2;
  localparam logic [1:0] WD_ACT_WAKE    = 2'h3;
  localparam logic [1:0] BTN_ACT_IRQ    = 2'h0;
  localparam logic [1:0] BTN_ACT_ON     = 2'h1;
  localparam logic [1:0] BTN_ACT_OFF    = 2'h2;

  // interrupt status bits
  localparam int IRQ_WD_FIRST   = 0;
  localparam int IRQ_WD_SECOND  = 1;
  localparam int IRQ_BTN_PRESS  = 2;
  localparam int IRQ_BTN_HOLD   = 3;

  typedef enum logic [1:0] {BTN_UP, BTN_HOLDING, BTN_HELD} btn_state_t;

endpackage : supervisor_pkg

// ### rtl/watchdog_supervisor.sv
// watchdog timer and power button supervisor with apb registers
//
// What this block does
// - Watchdog enable bit 15 resets to 1 and only gates counting, never clearing the count.
// - Pause bit 14 (reset 0) freezes the watchdog count while set.
// - In sleep the watchdog stops unless sleep enable bit 12 (reset 0) is set, then enable and pause decide.
// - Writing 1 to refresh bit 11 restarts the watchdog only when source bit 13 selects software.
// - After one period without refresh the primary action in bits 5:4 fires; period 0.256s doubling per step.
// - After two periods without refresh the secondary action in bits 9:8 fires.
// - Watchdog and button configuration fields take writes only while the key is unlocked.
// - A button press performs the press action in bits 5:4: ignore, on request or off request.
// - Every button press raises an interrupt whatever the press action.
// - Holding the button for one hold period performs the hold action in bits 9:8.
// - Hold period bits 1:0 select one, two, four or eight seconds.
// - Read-only bit 3 shows the live button level, 0 while pressed.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module watchdog_supervisor
  import supervisor_pkg::*;
#(
  parameter logic [CNT_W-1:0] WD_BASE_CYC  = CNT_W'(WD_BASE_CYCLES),
  parameter logic [CNT_W-1:0] BTN_BASE_CYC = CNT_W'(BTN_BASE_CYCLES)
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  // system inputs
  input  wire logic        button_n_i,
  input  wire logic        sleep_state_i,
  input  wire logic        hw_refresh_i,
  // requests and interrupt
  output var  logic        irq_o,
  output var  logic        dev_reset_o,
  output var  logic        wake_o,
  output var  logic        on_req_o,
  output var  logic        off_req_o
);

  // shifted period, shared by both timers
  function automatic logic [CNT_W-1:0] scaled(input logic [CNT_W-1:0] base, input logic [2:0] sel);
    return base << sel;
  endfunction : scaled

  // watchdog action code to {wake, reset, irq}
  function automatic logic [2:0] wd_act(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h0;
    unique case (code)
      WD_ACT_NONE:  r = 3'h0;
      WD_ACT_IRQ:   r = 3'h1;
      WD_ACT_RESET: r = 3'h2;
      WD_ACT_WAKE:  r = 3'h4;
    endcase
    return r;
  endfunction : wd_act

  logic             wd_enable_bit, next_wd_enable_bit;
  logic             wd_pause_bit, next_wd_pause_bit;
  logic             wd_refresh_source, next_wd_refresh_source;
  logic             wd_sleep_enable, next_wd_sleep_enable;
  logic [1:0]       wd_second_action, next_wd_second_action;
  logic [1:0]       wd_first_action, next_wd_first_action;
  logic [2:0]       wd_period_select, next_wd_period_select;
  logic [1:0]       button_hold_action, next_button_hold_action;
  logic [1:0]       button_press_action, next_button_press_action;
  logic [1:0]       button_hold_period, next_button_hold_period;
  logic             unlocked, next_unlocked;
  logic [3:0]       irq_status, next_irq_status;
  logic [3:0]       irq_mask, next_irq_mask;
  logic [CNT_W-1:0] wd_count, next_wd_count;
  logic [CNT_W-1:0] btn_count, next_btn_count;
  btn_state_t       btn_state, next_btn_state;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr, next_irq;
  logic             next_dev_reset, next_wake, next_on_req, next_off_req;

  // decoded terms, also watched by the checks
  logic             access, wr_wd, wr_btn;
  logic             refresh_any, wd_run;
  logic             wd_first_hit, wd_second_hit, btn_hold_hit;
  logic [CNT_W-1:0] wd_period, btn_period;
  logic [3:0]       irq_set, irq_clr;
  logic [2:0]       act;

  always_comb begin
    next_wd_enable_bit       = wd_enable_bit;
    next_wd_pause_bit        = wd_pause_bit;
    next_wd_refresh_source   = wd_refresh_source;
    next_wd_sleep_enable     = wd_sleep_enable;
    next_wd_second_action    = wd_second_action;
    next_wd_first_action     = wd_first_action;
    next_wd_period_select    = wd_period_select;
    next_button_hold_action  = button_hold_action;
    next_button_press_action = button_press_action;
    next_button_hold_period  = button_hold_period;
    next_unlocked            = unlocked;
    next_irq_mask            = irq_mask;
    next_btn_state           = btn_state;
    next_btn_count           = btn_count;
    next_dev_reset           = 1'b0;
    next_wake                = 1'b0;
    next_on_req              = 1'b0;
    next_off_req             = 1'b0;
    irq_set                  = 4'h0;
    irq_clr                  = 4'h0;
    act                      = 3'h0;

    // one wait state so read data comes from a flop
    access       = psel_i & penable_i;
    next_pready  = access & ~pready_o;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (access && !pready_o) begin
      if (paddr_i == ADDR_WD) begin
        next_prdata = {16'h0000, wd_enable_bit, wd_pause_bit, wd_refresh_source, wd_sleep_enable,
                       2'b00, wd_second_action, 2'b00, wd_first_action, 1'b0, wd_period_select};
      end else if (paddr_i == ADDR_BTN) begin
        next_prdata = {22'h000000, button_hold_action, 2'b00, button_press_action,
                       button_n_i, 1'b0, button_hold_period};
      end else if (paddr_i == ADDR_KEY) begin
        next_prdata = {31'h0000_0000, unlocked};
      end else if (paddr_i == ADDR_IRQ) begin
        next_prdata = {28'h000_0000, irq_status};
      end else if (paddr_i == ADDR_MASK) begin
        next_prdata = {28'h000_0000, irq_mask};
      end else begin
        next_pslverr = 1'b1;
      end
    end

    // writes land at the edge where pready is seen high
    wr_wd  = access & pready_o & pwrite_i & (paddr_i == ADDR_WD);
    wr_btn = access & pready_o & pwrite_i & (paddr_i == ADDR_BTN);
    if (access && pready_o && pwrite_i) begin
      if (paddr_i == ADDR_KEY) begin
        next_unlocked = (pwdata_i[15:0] == KEY_VALUE);
      end
      if (paddr_i == ADDR_IRQ) begin
        irq_clr = pwdata_i[3:0];
      end
      if (paddr_i == ADDR_MASK) begin
        next_irq_mask = pwdata_i[3:0];
      end
    end
    if (wr_wd && unlocked) begin
      next_wd_enable_bit     = pwdata_i[WD_ENA_BIT];
      next_wd_pause_bit      = pwdata_i[WD_PAUSE_BIT];
      next_wd_refresh_source = pwdata_i[WD_SRC_BIT];
      next_wd_sleep_enable   = pwdata_i[WD_SLP_BIT];
      next_wd_second_action  = pwdata_i[WD_SEC_LSB +: 2];
      next_wd_first_action   = pwdata_i[WD_PRI_LSB +: 2];
      next_wd_period_select  = pwdata_i[WD_TO_LSB +: 3];
    end
    if (wr_btn && unlocked) begin
      next_button_hold_action  = pwdata_i[BTN_HOLD_LSB +: 2];
      next_button_press_action = pwdata_i[BTN_PRESS_LSB +: 2];
      next_button_hold_period  = pwdata_i[BTN_TO_LSB +: 2];
    end

    // refresh bit is not key protected and always reads back 0
    refresh_any = (wr_wd & pwdata_i[WD_REFRESH_BIT] & wd_refresh_source)
                | (hw_refresh_i & ~wd_refresh_source);
    wd_run = wd_enable_bit & ~wd_pause_bit & ~(sleep_state_i & ~wd_sleep_enable);
    wd_period     = scaled(WD_BASE_CYC, wd_period_select);
    wd_first_hit  = wd_run & ~refresh_any & (wd_count == wd_period - CNT_W'(1));
    wd_second_hit = wd_run & ~refresh_any & (wd_count == (wd_period << 1) - CNT_W'(1));
    next_wd_count = wd_count;
    if (refresh_any) begin
      next_wd_count = '0;
    end else if (wd_second_hit) begin
      next_wd_count = '0;
    end else if (wd_run) begin
      next_wd_count = wd_count + CNT_W'(1);
    end
    if (wd_first_hit) begin
      act = wd_act(wd_first_action);
      irq_set[IRQ_WD_FIRST] = act[0];
    end else if (wd_second_hit) begin
      act = wd_act(wd_second_action);
      irq_set[IRQ_WD_SECOND] = act[0];
    end
    next_dev_reset = act[1];
    next_wake      = act[2];

    // button: pin is active low, taken as synchronous
    btn_period   = scaled(BTN_BASE_CYC, {1'b0, button_hold_period});
    btn_hold_hit = (btn_state == BTN_HOLDING) & ~button_n_i & (btn_count == btn_period - CNT_W'(1));
    unique case (btn_state)
      BTN_UP: begin
        if (!button_n_i) begin
          irq_set[IRQ_BTN_PRESS] = 1'b1;
          next_on_req    = (button_press_action == BTN_ACT_ON);
          next_off_req   = (button_press_action == BTN_ACT_OFF);
          next_btn_count = '0;
          next_btn_state = BTN_HOLDING;
        end
      end
      BTN_HOLDING: begin
        if (button_n_i) begin
          next_btn_state = BTN_UP;
        end else if (btn_hold_hit) begin
          irq_set[IRQ_BTN_HOLD] = (button_hold_action == BTN_ACT_IRQ);
          next_on_req    = (button_hold_action == BTN_ACT_ON);
          next_off_req   = (button_hold_action == BTN_ACT_OFF);
          next_btn_state = BTN_HELD;
        end else begin
          next_btn_count = btn_count + CNT_W'(1);
        end
      end
      BTN_HELD: begin
        // one hold action per press; wait for release
        if (button_n_i) begin
          next_btn_state = BTN_UP;
        end
      end
    endcase

    // set wins over a write-one clear in the same cycle
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
    next_irq        = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wd_enable_bit       <= WD_ENA_RST;
      wd_pause_bit        <= WD_PAUSE_RST;
      wd_refresh_source   <= WD_SRC_RST;
      wd_sleep_enable     <= WD_SLP_RST;
      wd_second_action    <= WD_SEC_RST;
      wd_first_action     <= WD_PRI_RST;
      wd_period_select    <= WD_TO_RST;
      button_hold_action  <= BTN_HOLD_RST;
      button_press_action <= BTN_PRESS_RST;
      button_hold_period  <= BTN_TO_RST;
      unlocked            <= 1'b0;
      irq_status          <= 4'h0;
      irq_mask            <= 4'h0;
      wd_count            <= '0;
      btn_count           <= '0;
      btn_state           <= BTN_UP;
      prdata_o            <= 32'h0000_0000;
      pready_o            <= 1'b0;
      pslverr_o           <= 1'b0;
      irq_o               <= 1'b0;
      dev_reset_o         <= 1'b0;
      wake_o              <= 1'b0;
      on_req_o            <= 1'b0;
      off_req_o           <= 1'b0;
    end else begin
      wd_enable_bit       <= next_wd_enable_bit;
      wd_pause_bit        <= next_wd_pause_bit;
      wd_refresh_source   <= next_wd_refresh_source;
      wd_sleep_enable     <= next_wd_sleep_enable;
      wd_second_action    <= next_wd_second_action;
      wd_first_action     <= next_wd_first_action;
      wd_period_select    <= next_wd_period_select;
      button_hold_action  <= next_button_hold_action;
      button_press_action <= next_button_press_action;
      button_hold_period  <= next_button_hold_period;
      unlocked            <= next_unlocked;
      irq_status          <= next_irq_status;
      irq_mask            <= next_irq_mask;
      wd_count            <= next_wd_count;
      btn_count           <= next_btn_count;
      btn_state           <= next_btn_state;
      prdata_o            <= next_prdata;
      pready_o            <= next_pready;
      pslverr_o           <= next_pslverr;
      irq_o               <= next_irq;
      dev_reset_o         <= next_dev_reset;
      wake_o              <= next_wake;
      on_req_o            <= next_on_req;
      off_req_o           <= next_off_req;
    end
  end

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  chk_enable_keeps_count: assert property (
    $rose(wd_enable_bit) && !$past(refresh_any) |-> wd_count == $past(wd_count))
    else $error("enabling the watchdog changed its count");

  chk_pause_freezes: assert property (
    $past(wd_pause_bit) && !$past(refresh_any) |-> wd_count == $past(wd_count))
    else $error("watchdog counted while paused");

  chk_sleep_stops: assert property (
    $past(sleep_state_i && !wd_sleep_enable && !refresh_any) |-> wd_count == $past(wd_count))
    else $error("watchdog counted in sleep without sleep enable");

  chk_sw_refresh_only: assert property (
    wr_wd && pwdata_i[WD_REFRESH_BIT] && !wd_refresh_source && !hw_refresh_i && wd_run
      && !wd_second_hit |=> wd_count == $past(wd_count) + CNT_W'(1))
    else $error("software refresh taken while hardware source selected");

  chk_first_reset: assert property (
    wd_first_hit && wd_first_action == WD_ACT_RESET |=> dev_reset_o && !wake_o)
    else $error("primary reset action missing");

  chk_second_wake: assert property (
    wd_second_hit && wd_second_action == WD_ACT_WAKE |=> wake_o ##1 !wake_o)
    else $error("secondary wake action missing or too long");

  chk_locked_write: assert property (
    (wr_wd || wr_btn) && !unlocked |=> $stable(wd_period_select) && $stable(button_hold_period))
    else $error("protected field changed while locked");

  chk_press_on: assert property (
    btn_state == BTN_UP && !button_n_i && button_press_action == BTN_ACT_ON |=> on_req_o && !off_req_o)
    else $error("press on request missing");

  chk_press_irq: assert property (
    btn_state == BTN_UP && !button_n_i |=> irq_status[IRQ_BTN_PRESS])
    else $error("button press did not raise its interrupt");

  chk_hold_off: assert property (
    btn_hold_hit && button_hold_action == BTN_ACT_OFF |=> off_req_o && btn_state == BTN_HELD)
    else $error("hold off request missing");

  chk_hold_length: assert property (
    btn_state == BTN_HOLDING && !button_n_i
      && btn_count == (BTN_BASE_CYC << button_hold_period) - CNT_W'(1) |=> btn_state == BTN_HELD)
    else $error("hold period length wrong");

  chk_level_read: assert property (
    access && !pready_o && !pwrite_i && paddr_i == ADDR_BTN |=> prdata_o[BTN_LEVEL_BIT] == $past(button_n_i))
    else $error("button level read wrong");

  chk_refresh_zero: assert property (
    refresh_any || wd_second_hit |=> wd_count == '0)
    else $error("watchdog count not restarted");

  chk_early_release: assert property (
    btn_state == BTN_HOLDING && button_n_i |=> btn_state == BTN_UP && !on_req_o && !off_req_o)
    else $error("early release took an action");

  cov_wd_first:  cover property (wd_first_hit);
  cov_wd_second: cover property (wd_second_hit);
  cov_btn_hold:  cover property (btn_hold_hit);
  cov_irq_clear: cover property (irq_o ##1 !irq_o);

endmodule : watchdog_supervisor

`default_nettype wire

// ### tb/button_model.sv
// power button model: pulled up while released, low while pressed
`timescale 1ns/1ps
`default_nettype none

module button_model (
  // clock
  input  wire logic mclk_i,
  // bench command
  input  wire logic press_i,
  // pin
  output var  logic button_n_o
);
  // the pull-up keeps the pin high whenever nobody presses
  initial button_n_o = 1'b1;

  always @(posedge mclk_i) begin
    button_n_o <= ~press_i;
  end
endmodule : button_model

`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the watchdog and power button supervisor
`timescale 1ns/1ps
`default_nettype none

module testbench
  import supervisor_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        button_n;
  logic        press = 1'b0;
  logic        sleep_state = 1'b0;
  logic        hw_refresh = 1'b0;
  logic        irq;
  logic        dev_reset;
  logic        wake;
  logic        on_req;
  logic        off_req;
  logic        mask_on = 1'b0;
  int          rst_cnt = 0;
  int          wake_cnt = 0;
  int          on_cnt = 0;
  int          off_cnt = 0;
  int          failures = 0;
  int          cmp_count = 0;
  logic [31:0] r;
  logic        e;
  int          r0;
  logic [15:0] bcfg [5] = '{16'h0120, 16'h0001, 16'h0001, 16'h0211, 16'h0333};
  int          bhold [5] = '{30, 20, 45, 45, 140};
  int          bact [5] = '{1, 0, 0, 1, 0};
  logic [31:0] bsts [5] = '{32'h4, 32'h4, 32'hC, 32'h4, 32'h4};

  always #10 mclk = ~mclk;

  watchdog_supervisor #(.WD_BASE_CYC(33'h8), .BTN_BASE_CYC(33'h10)) i_watchdog_supervisor (
    .mclk_i(mclk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .button_n_i(button_n), .sleep_state_i(sleep_state), .hw_refresh_i(hw_refresh), .irq_o(irq),
    .dev_reset_o(dev_reset), .wake_o(wake), .on_req_o(on_req), .off_req_o(off_req));

  button_model i_button_model (.mclk_i(mclk), .press_i(press), .button_n_o(button_n));

  // request pulses stand one cycle, so each high sample is one request
  always @(posedge mclk) begin
    if (dev_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (on_req === 1'b1) on_cnt <= on_cnt + 1;
    if (off_req === 1'b1) off_cnt <= off_cnt + 1;
  end

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // apb master; request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd_o,
                      output logic err_o);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      $display("Error at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
      failures++;
      test_done();
    end
    rd_o = prdata;
    err_o = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rd

  // one watchdog run from a fresh refresh, stopped by disabling before the first repeat
  task automatic wd_window(input logic [15:0] cfg, input int exp_rst, input int exp_wake, input logic [31:0] exp_sts);
    int w0;
    r0 = rst_cnt;
    w0 = wake_cnt;
    wr(ADDR_WD, {16'h0, cfg});
    idle(15);
    // keep the software source so the next window's refresh write is honoured
    wr(ADDR_WD, 32'h00002210);
    check(32'(rst_cnt - r0), 32'(exp_rst));
    check(32'(wake_cnt - w0), 32'(exp_wake));
    rd(ADDR_IRQ, exp_sts);
    check({31'h0, irq}, {31'h0, (exp_sts != 32'h0) & mask_on});
    wr(ADDR_IRQ, 32'h0000000F);
    idle(2);
    check({31'h0, irq}, 32'h0);
  endtask : wd_window

  task automatic btn_case(input int i);
    int o0;
    int f0;
    wr(ADDR_BTN, {16'h0, bcfg[i]});
    o0 = on_cnt;
    f0 = off_cnt;
    press <= 1'b1;
    idle(bhold[i]);
    rd(ADDR_BTN, {16'h0, bcfg[i]});
    press <= 1'b0;
    idle(4);
    rd(ADDR_BTN, {16'h0, bcfg[i] | 16'h0008});
    check(32'(on_cnt - o0), 32'(bact[i]));
    check(32'(off_cnt - f0), 32'(bact[i]));
    rd(ADDR_IRQ, bsts[i]);
    wr(ADDR_IRQ, 32'h0000000F);
  endtask : btn_case

  initial begin
    idle(4);
    rstn <= 1'b1;
    rd(ADDR_WD, 32'h0000A217);
    rd(ADDR_BTN, 32'h00000108);
    xfer(1'b0, 32'h00000004, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    wr(ADDR_WD, 32'h0);
    wr(ADDR_BTN, 32'h00000333);
    rd(ADDR_WD, 32'h0000A217);
    rd(ADDR_BTN, 32'h00000108);
    $display("test reset and lock done");
    wr(ADDR_KEY, 32'h00009716);
    wr(ADDR_MASK, 32'h0000000F);
    mask_on = 1'b1;
    for (int p = 0; p < 4; p++) begin
      wd_window(16'hA800 | 16'((p + 2) % 4) << 8 | 16'(p) << 4, int'(p == 2) + int'((p + 2) % 4 == 2),
                int'(p == 3) + int'((p + 2) % 4 == 3), {30'h0, ((p + 2) % 4) == 1, p == 1});
    end
    wr(ADDR_MASK, 32'h0);
    mask_on = 1'b0;
    wd_window(16'hA810, 0, 0, 32'h1);
    wr(ADDR_MASK, 32'h0000000F);
    mask_on = 1'b1;
    $display("test watchdog actions done");
    wd_window(16'hEA10, 0, 0, 32'h0);
    sleep_state <= 1'b1;
    wd_window(16'hAA10, 0, 0, 32'h0);
    wd_window(16'hBA10, 1, 0, 32'h1);
    sleep_state <= 1'b0;
    hw_refresh <= 1'b1;
    wd_window(16'h8A10, 0, 0, 32'h0);
    hw_refresh <= 1'b0;
    r0 = rst_cnt;
    wr(ADDR_WD, 32'h00008210);
    // software refresh is ignored while the source is hardware
    repeat (6) wr(ADDR_WD, 32'h00008A10);
    wr(ADDR_WD, 32'h00000210);
    check({31'h0, rst_cnt != r0}, 32'h1);
    wr(ADDR_IRQ, 32'h0000000F);
    $display("test pause sleep refresh done");
    for (int i = 0; i < 5; i++) btn_case(i);
    $display("test button done");
    test_done();
  end
endmodule : testbench

`default_nettype wire
